// File: bench/core_model.sv
// core side: register accesses and interrupt entry and return events
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       clk,
    output logic            direct,
    output logic            wr,
    output logic            rd,
    output logic            ent,
    output logic            ret,
    output logic      [7:0] addr,
    output logic      [7:0] wdata
);
    initial {direct, wr, rd, ent, ret, addr, wdata} = '0;
    // released address and data lines show the inverse, never a stale copy
    task automatic acc(input logic w, dir, input logic [7:0] a, d);
        {direct, wr, rd, addr, wdata} = {dir, w, !w, a, d};
        @(posedge clk);
        #1;
        {wr, rd, addr, wdata} = {2'b00, ~a, ~d};
        @(posedge clk);
        #1;
    endtask : acc
    task automatic ev(input logic push);
        {ent, ret} = {push, !push};
        @(posedge clk);
        #1;
        {ent, ret} = 2'b00;
        @(posedge clk);
        #1;
    endtask : ev
endmodule : core_model
`default_nettype wire

// File: bench/sfr_page_stack_properties.sv
// port assertions for the page stack block
`timescale 1ns/1ps
`default_nettype none
`include "sfr_page_regs.svh"
module sfr_page_checker #(
    parameter int PAGE_W = 8
) (
    input wire logic              REF_CLK,
    input wire logic              SYS_RST,
    input wire logic              CLK_EN,
    input wire logic              ACC_DIRECT,
    input wire logic              ACC_WR,
    input wire logic              ACC_RD,
    input wire logic              INT_ENTRY,
    input wire logic              RETURN_FROM_INTERRUPT,
    input wire logic              ACC_RVALID,
    input wire logic              ACC_HIT,
    input wire logic              AUTO_PAGE_EN,
    input wire logic [7:0]        ACC_ADDR,
    input wire logic [7:0]        ACC_WDATA,
    input wire logic [7:0]        ACC_RDATA,
    input wire logic [PAGE_W-1:0] CURRENT_PAGE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    // frozen cycles take no access
    wire logic pg_wr = CLK_EN && ACC_WR && ACC_DIRECT && ACC_ADDR == `ADDR_CURRENT_PAGE;
    wire logic dir_rd = CLK_EN && ACC_RD && ACC_DIRECT;
    wire logic evt = INT_ENTRY || RETURN_FROM_INTERRUPT;
    sequence s_page_rd; dir_rd && ACC_ADDR == `ADDR_CURRENT_PAGE; endsequence
    sequence s_answer; ACC_HIT ##1 ACC_RVALID; endsequence
    property p_rd_walk; s_page_rd |-> ##1 s_answer; endproperty
    a_rd_walk: assert property (p_rd_walk) else $error("stack read not answered");
    property p_rv_cause; ACC_RVALID |-> $past(dir_rd, 2); endproperty
    a_rv_cause: assert property (p_rv_cause) else $error("read data without direct read");
    property p_indirect; (ACC_RD || ACC_WR) && !ACC_DIRECT |=> !ACC_HIT; endproperty
    a_indirect: assert property (p_indirect) else $error("indirect access hit");
    property p_idle; !ACC_RVALID |-> ACC_RDATA == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_push;
        CLK_EN && INT_ENTRY && AUTO_PAGE_EN |-> ##2 CURRENT_PAGE == 8'h00;
    endproperty
    a_push: assert property (p_push) else $error("entry did not force page zero");
    property p_hold; !pg_wr && !evt |-> ##2 $stable(CURRENT_PAGE); endproperty
    a_hold: assert property (p_hold) else $error("page moved without cause");
    property p_pg_wr; pg_wr && !evt |-> ##2 CURRENT_PAGE == $past(ACC_WDATA, 2); endproperty
    a_pg_wr: assert property (p_pg_wr) else $error("page write not applied");
    property p_no_auto; evt && !AUTO_PAGE_EN && !pg_wr |-> ##2 $stable(CURRENT_PAGE); endproperty
    a_no_auto: assert property (p_no_auto) else $error("paging while disabled");
    property p_en_rst; $fell(SYS_RST) |-> AUTO_PAGE_EN; endproperty
    a_en_rst: assert property (p_en_rst) else $error("enable clear after reset");
endmodule : sfr_page_checker
bind sfr_page_stack sfr_page_checker #(.PAGE_W(PAGE_W)) chk (.REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .ACC_DIRECT(ACC_DIRECT), .ACC_WR(ACC_WR),
    .ACC_RD(ACC_RD), .INT_ENTRY(INT_ENTRY), .RETURN_FROM_INTERRUPT(RETURN_FROM_INTERRUPT),
    .ACC_RVALID(ACC_RVALID), .ACC_HIT(ACC_HIT), .AUTO_PAGE_EN(AUTO_PAGE_EN),
    .ACC_ADDR(ACC_ADDR), .ACC_WDATA(ACC_WDATA), .ACC_RDATA(ACC_RDATA),
    .CURRENT_PAGE(CURRENT_PAGE));
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the page stack block
`timescale 1ns/1ps
`default_nettype none
`include "sfr_page_regs.svh"
module testbench;
    logic       clk = 0, rst = 1, ce = 1;
    logic       direct, wr, rd, ent, ret, rvalid, hit, apen;
    logic [7:0] addr, wdata, rdata, page;
    int fails = 0, comparisons = 0, seed = 32'hd092, cur = 0, mid = 0, bot = 0, en = 1, r;
    int pm[int];
    int ra[4] = '{'hA7, 'h85, 'h86, 'hE5};
    always #2.5 clk = ~clk;
    core_model core (.clk(clk), .direct(direct), .wr(wr), .rd(rd), .ent(ent), .ret(ret),
        .addr(addr), .wdata(wdata));
    sfr_page_stack dut (.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .ACC_DIRECT(direct),
        .ACC_WR(wr), .ACC_RD(rd), .ACC_ADDR(addr), .ACC_WDATA(wdata), .INT_ENTRY(ent),
        .RETURN_FROM_INTERRUPT(ret), .ACC_RDATA(rdata), .ACC_RVALID(rvalid), .ACC_HIT(hit),
        .CURRENT_PAGE(page), .AUTO_PAGE_EN(apen));
    function automatic bit glob(input int a);
        return a % 16 == 0 && a < 'hC0;
    endfunction : glob
    function automatic int key(input int a);
        return glob(a) ? a : cur * 256 + a;
    endfunction : key
    function automatic int expv(input int a);
        case (a)
            'hA7: return cur;
            'h85: return mid;
            'h86: return bot;
            'hE5: return en;
            default: return (cur == 0 || cur == 15 || glob(a)) ? pm[key(a)] : 0;
        endcase
    endfunction : expv
    task automatic wrt(input int a, d);
        core.acc(1, 1, a[7:0], d[7:0]);
        case (a)
            'hA7: cur = d;
            'h85: mid = d;
            'h86: bot = d;
            'hE5: en = d & 1;
            default: if (cur == 0 || cur == 15 || glob(a)) pm[key(a)] = d;
        endcase
    endtask : wrt
    task automatic rdc(input int a);
        core.acc(0, 1, a[7:0], 8'h00);
        comparisons++;
        if ({rvalid, rdata, page, apen} !== {1'b1, 8'(expv(a)), 8'(cur), 1'(en)})
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, {rvalid, rdata, page, apen},
                     {1'b1, 8'(expv(a)), 8'(cur), 1'(en)});
        end
    endtask : rdc
    task automatic summarize;
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    initial
    begin
        #100000;
        fails++;
        summarize();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        #1 rst = 0;
        foreach (ra[i]) rdc(ra[i]);
        for (int p = 0; p < 16; p += 15)
        begin
            wrt('hA7, p);
            wrt('hC0, p + 1);
            wrt('hC8, p + 2);
            wrt('h90, p + 3);
        end
        // clock enable low: an entry and a page write must leave no trace
        ce = 0;
        core.ev(1);
        core.acc(1, 1, 8'hA7, 8'h33);
        ce = 1;
        foreach (ra[i]) rdc(ra[i]);
        repeat (300)
        begin
            r = $random(seed);
            case (r[2:0])
                0: wrt('hA7, r[4:3] == 0 ? 15 : r[4:3] == 1 ? 0 : r[15:8]);
                1: wrt(r[3] ? 'hC0 : 'hC8, r[15:8]);
                2:
                begin
                    core.ev(1);
                    if (en)
                    begin
                        bot = mid;
                        mid = cur;
                        cur = 0;
                    end
                end
                3:
                begin
                    core.ev(0);
                    if (en)
                    begin
                        cur = mid;
                        mid = bot;
                        bot = 0;
                    end
                end
                4: wrt(r[3] ? 'h85 : 'h86, r[15:8]);
                5: wrt('hE5, r[15:8] | (r[4:3] != 0));
                6: core.acc(1, 0, r[3] ? 8'hC0 : 8'hA7, r[15:8]);
                7: wrt('h90, r[15:8]);
            endcase
            foreach (ra[i]) rdc(ra[i]);
            rdc(r[3] ? 'hC0 : 'hC8);
            rdc('h90);
        end
        summarize();
    end
endmodule : testbench
`default_nettype wire

// File: hw/paged_reg_mem.sv
// storage for the paged special registers of page 0 and page F
`timescale 1ns/1ps
`default_nettype none
module paged_reg_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata_q
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (ce && we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= 8'h00;
        end
        else if (ce)
        begin
            rdata_q <= mem[raddr];
        end
    end
endmodule : paged_reg_mem
`default_nettype wire

// File: hw/sfr_page_stack.sv
// special register page selection with interrupt page stack
`timescale 1ns/1ps
`default_nettype none
`include "sfr_page_regs.svh"
module sfr_page_stack #(
    parameter int PAGE_W = 8
) (
    input  wire logic              REF_CLK,
    input  wire logic              SYS_RST,
    input  wire logic              CLK_EN,
    input  wire logic              ACC_DIRECT,
    input  wire logic              ACC_WR,
    input  wire logic              ACC_RD,
    input  wire logic [7:0]        ACC_ADDR,
    input  wire logic [7:0]        ACC_WDATA,
    input  wire logic              INT_ENTRY,
    input  wire logic              RETURN_FROM_INTERRUPT,
    output logic      [7:0]        ACC_RDATA,
    output logic                   ACC_RVALID,
    output logic                   ACC_HIT,
    output logic      [PAGE_W-1:0] CURRENT_PAGE,
    output logic                   AUTO_PAGE_EN
);
    logic [PAGE_W-1:0]    current_page_select_q;
    logic [PAGE_W-1:0]    page_stack_middle_q;
    logic [PAGE_W-1:0]    page_stack_bottom_q;
    logic                 auto_page_enable_q;
    logic                 sfr_acc;
    logic                 push;
    logic                 pop;
    sfr_page_pkg::route_t rd_route;
    sfr_page_pkg::route_t wr_route;
    logic                 mem_we;
    logic [7:0]           mem_rdata;
    logic [7:0]           mem_waddr;
    logic [7:0]           mem_raddr;
    logic [7:0]           stack_rdata;
    logic [7:0]           stack_rdata_q;
    logic                 rd_paged_q;
    logic                 rd_q;

    // ports and the stack registers themselves bypass paging
    function automatic logic is_global(input logic [7:0] a);
        is_global = (a == `PORT_ADDR_0) || (a == `PORT_ADDR_1) ||
                    (a == `PORT_ADDR_2) || (a == `PORT_ADDR_3);
    endfunction : is_global

    function automatic logic is_stack(input logic [7:0] a);
        is_stack = (a == `ADDR_CURRENT_PAGE) || (a == `ADDR_STACK_MIDDLE) ||
                   (a == `ADDR_STACK_BOTTOM) || (a == `ADDR_PAGE_CONTROL);
    endfunction : is_stack

    // routing uses the page register as it stands this cycle
    function automatic sfr_page_pkg::route_t route_of(input logic [7:0] a,
                                                       input logic [PAGE_W-1:0] pg);
        if (is_stack(a))
            route_of = sfr_page_pkg::ROUTE_STACK;
        else if (is_global(a))
            route_of = sfr_page_pkg::ROUTE_GLOBAL;
        else if ((pg == PAGE_W'(`PAGE_ZERO)) || (pg == PAGE_W'(`PAGE_F)))
            route_of = sfr_page_pkg::ROUTE_PAGED;
        else
            route_of = sfr_page_pkg::ROUTE_NONE;
    endfunction : route_of

    // upper half only, direct mode only; indirect goes to data memory
    assign sfr_acc  = ACC_DIRECT && (ACC_ADDR >= `ADDR_SFR_LOW);
    assign rd_route = route_of(ACC_ADDR, current_page_select_q);
    assign wr_route = route_of(ACC_ADDR, current_page_select_q);

    assign push = INT_ENTRY && auto_page_enable_q;
    assign pop  = RETURN_FROM_INTERRUPT && auto_page_enable_q;

    // memory slot: page select bit above low seven address bits;
    // ports keep one slot so every page sees the same register
    assign mem_waddr = {(current_page_select_q == PAGE_W'(`PAGE_F)) && !is_global(ACC_ADDR),
                        ACC_ADDR[6:0]};
    assign mem_raddr = mem_waddr;
    assign mem_we    = sfr_acc && ACC_WR && (wr_route != sfr_page_pkg::ROUTE_STACK) &&
                       (wr_route != sfr_page_pkg::ROUTE_NONE);

    // current page; a software write in the same cycle as a push loses
    // because the interrupt entry happens before the handler runs
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            current_page_select_q <= PAGE_W'(`PAGE_RESET);
        else if (CLK_EN)
        begin
            if (push)
                current_page_select_q <= PAGE_W'(`PAGE_ZERO);
            else if (pop)
                current_page_select_q <= page_stack_middle_q;
            else if (sfr_acc && ACC_WR && ACC_ADDR == `ADDR_CURRENT_PAGE)
                current_page_select_q <= ACC_WDATA[PAGE_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            page_stack_middle_q <= PAGE_W'(`PAGE_RESET);
        else if (CLK_EN)
        begin
            if (push)
                page_stack_middle_q <= current_page_select_q;
            else if (pop)
                page_stack_middle_q <= page_stack_bottom_q;
            else if (sfr_acc && ACC_WR && ACC_ADDR == `ADDR_STACK_MIDDLE)
                page_stack_middle_q <= ACC_WDATA[PAGE_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            page_stack_bottom_q <= PAGE_W'(`PAGE_RESET);
        else if (CLK_EN)
        begin
            if (push)
                page_stack_bottom_q <= page_stack_middle_q;
            else if (pop)
                page_stack_bottom_q <= PAGE_W'(`PAGE_ZERO);
            else if (sfr_acc && ACC_WR && ACC_ADDR == `ADDR_STACK_BOTTOM)
                page_stack_bottom_q <= ACC_WDATA[PAGE_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            auto_page_enable_q <= 1'(`PAGE_CONTROL_RESET >> `AUTO_PAGE_BIT);
        else if (CLK_EN && sfr_acc && ACC_WR && ACC_ADDR == `ADDR_PAGE_CONTROL)
            auto_page_enable_q <= ACC_WDATA[`AUTO_PAGE_BIT];
    end

    // stack entries readable at their own addresses
    always_comb
    begin
        case (ACC_ADDR)
            `ADDR_CURRENT_PAGE: stack_rdata = 8'(current_page_select_q);
            `ADDR_STACK_MIDDLE: stack_rdata = 8'(page_stack_middle_q);
            `ADDR_STACK_BOTTOM: stack_rdata = 8'(page_stack_bottom_q);
            `ADDR_PAGE_CONTROL: stack_rdata = {`RESERVED_ZERO, auto_page_enable_q};
            default:            stack_rdata = 8'h00;
        endcase
    end

    paged_reg_mem #(
        .DEPTH (`PAGED_SLOTS * 2),
        .AW    (8)
    ) u_mem (
        .clk     (REF_CLK),
        .rst     (SYS_RST),
        .ce      (CLK_EN),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (ACC_WDATA),
        .raddr   (mem_raddr),
        .rdata_q (mem_rdata)
    );

    // read pipeline: one cycle, aligned with the memory's registered output
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rd_q          <= 1'b0;
            rd_paged_q    <= 1'b0;
            stack_rdata_q <= 8'h00;
            ACC_HIT       <= 1'b0;
        end
        else if (CLK_EN)
        begin
            rd_q          <= sfr_acc && ACC_RD;
            rd_paged_q    <= (rd_route == sfr_page_pkg::ROUTE_PAGED) ||
                             (rd_route == sfr_page_pkg::ROUTE_GLOBAL);
            stack_rdata_q <= (rd_route == sfr_page_pkg::ROUTE_STACK) ? stack_rdata : 8'h00;
            ACC_HIT       <= sfr_acc && (ACC_RD || ACC_WR) &&
                             (rd_route != sfr_page_pkg::ROUTE_NONE);
        end
    end

    // output stage kept registered; adds one cycle of read latency
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ACC_RDATA  <= 8'h00;
            ACC_RVALID <= 1'b0;
        end
        else if (CLK_EN)
        begin
            ACC_RVALID <= rd_q;
            ACC_RDATA  <= rd_q ? (rd_paged_q ? mem_rdata : stack_rdata_q) : 8'h00;
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            CURRENT_PAGE <= PAGE_W'(`PAGE_RESET);
            AUTO_PAGE_EN <= 1'b1;
        end
        else if (CLK_EN)
        begin
            CURRENT_PAGE <= current_page_select_q;
            AUTO_PAGE_EN <= auto_page_enable_q;
        end
    end
endmodule : sfr_page_stack
`default_nettype wire

// File: include/sfr_page_pkg.sv
// types shared by the page stack block
package sfr_page_pkg;
    typedef enum logic [1:0] {
        ROUTE_NONE,
        ROUTE_STACK,
        ROUTE_GLOBAL,
        ROUTE_PAGED
    } route_t;
endpackage : sfr_page_pkg

// File: include/sfr_page_regs.svh
// register addresses, field positions and reset values of the page stack block
`ifndef SFR_PAGE_REGS_SVH
`define SFR_PAGE_REGS_SVH
`define ADDR_CURRENT_PAGE   8'hA7
`define ADDR_STACK_MIDDLE   8'h85
`define ADDR_STACK_BOTTOM   8'h86
`define ADDR_PAGE_CONTROL   8'hE5
`define ADDR_SFR_LOW        8'h80
`define PAGE_ZERO           8'h00
`define PAGE_F              8'h0F
`define PAGE_RESET          8'h00
`define AUTO_PAGE_BIT       0
`define PAGE_CONTROL_RESET  8'h01
`define RESERVED_ZERO       7'h00
`define PAGE_COUNT          256
`define PAGED_SLOTS         128
`define PORT_ADDR_0         8'h80
`define PORT_ADDR_1         8'h90
`define PORT_ADDR_2         8'hA0
`define PORT_ADDR_3         8'hB0
`define PAGE_SEL_ZERO       1'b0
`define PAGE_SEL_F          1'b1
`endif
